// *** common/scl_regs.svh ***
// Constants of the security compliance and lock-state link: layouts, codes, host registers.
// Assumes inclusion by bare name from the modules and the bench.
`ifndef SCL_REGS_SVH
`define SCL_REGS_SVH
// Compliance descriptor layout
`define SCL_DESC_TYPE 16'h0001
`define SCL_DESC_LEN 32'h0000_0208
`define SCL_DESC_SPAN 32'h0000_0210
`define SCL_DESC_LAST 10'h20F
`define SCL_OFF_LEN 10'h004
`define SCL_OFF_REL 10'h008
`define SCL_OFF_LVL 10'h009
`define SCL_OFF_HW 10'h010
`define SCL_OFF_HW_END 10'h08F
`define SCL_OFF_VER 10'h090
`define SCL_OFF_VER_END 10'h10F
`define SCL_OFF_NAME 10'h110
`define SCL_INFO_HDR 16'h0004
`define SCL_STD_REV2 8'h32
`define SCL_STD_REV3 8'h33
`define SCL_PAD 8'h00
// Protocol codes
`define SCL_PROTO_INFO 8'h00
`define SCL_SPEC_COMPL 16'h0002
`define SCL_PROTO_TCG 8'h02
`define SCL_COMID_BLK 16'h0005
`define SCL_FEAT_BLK 16'h0402
// Host register offsets
`define SCL_R_CTRL 8'h00
`define SCL_R_CMD 8'h04
`define SCL_R_LEN 8'h08
`define SCL_R_ARG 8'h0C
`define SCL_R_STAT 8'h10
`define SCL_R_RSP 8'h14
// Host control fields
`define SCL_CTRL_GO 0
`define SCL_CTRL_OP 7:4
`define SCL_CTRL_MAC 9:8
`define SCL_PROV_ARG 8'h03
`endif

// *** common/scl_pkg.sv ***
// Types shared by both ends of the security compliance link.
// Assumes the constants header sits beside it.
package scl_pkg;
    // Link command codes
    typedef enum logic [3:0] {
        OP_SEC_IN = 4'h0,
        OP_TSEND = 4'h1,
        OP_LOCK_ACCESS = 4'h2,
        OP_AUTH_OWNER = 4'h3,
        OP_REVERT = 4'h4,
        OP_DISCOVERY = 4'h5,
        OP_SESS_ADMIN = 4'h6,
        OP_SESS_END = 4'h7,
        OP_AUTH_PHYS = 4'h8,
        OP_MAKER_OFF = 4'h9,
        OP_PORT_LOCK = 4'hA,
        OP_HW_RESET = 4'hB
    } scl_op_t;
    // Host command sequences
    typedef enum logic [1:0] {
        MAC_SINGLE = 2'h0,
        MAC_ZEROIZE = 2'h1,
        MAC_PROVISION = 2'h2
    } scl_mac_t;
    typedef enum logic [3:0] {
        D_IDLE = 4'h1,
        D_RX = 4'h2,
        D_TX = 4'h4,
        D_DONE = 4'h8
    } scl_dst_t;
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_ISSUE = 4'h2,
        H_PAY = 4'h4,
        H_WAIT = 4'h8
    } scl_hst_t;
endpackage

// *** common/scl_link_if.sv ***
// Link between the host controller and the drive's security logic.
// Assumes one common clock; all signals change after its rising edge.
`timescale 1ns/1ps
interface scl_link_if;
    logic req;
    scl_pkg::scl_op_t op;
    logic [7:0] proto;
    logic [15:0] comid;
    logic [15:0] len;
    logic [15:0] alloc;
    logic [7:0] arg;
    logic pay_valid;
    logic [7:0] pay_data;
    logic rdy;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic done;
    logic rej;
    modport dev (
        input req, op, proto, comid, len, alloc, arg, pay_valid, pay_data,
        output rdy, rsp_valid, rsp_data, done, rej
    );
    modport host (
        output req, op, proto, comid, len, alloc, arg, pay_valid, pay_data,
        input rdy, rsp_valid, rsp_data, done, rej
    );
endinterface

// *** verilog/scl_dev.sv ***
// Drive-side security logic: compliance data, security mode and owner-authentication block.
// Assumes the host keeps the link handshake and payload conventions.
`timescale 1ns/1ps
`include "scl_regs.svh"
module scl_dev import scl_pkg::*; #(
    parameter int NUM_DESC = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Link to host
    scl_link_if.dev link,
    // Certified module identity
    input wire logic fips_rev3,
    input wire logic [7:0] sec_level,
    input wire logic [1023:0] hw_str,
    input wire logic [1023:0] ver_str,
    input wire logic [2047:0] name_str,
    // Security state
    output logic ise_mode,
    output logic enforce_long_limits,
    output logic fw_port_locked,
    output logic owner_auth_blocked,
    output logic user_data_erase,
    output logic certified
);
    localparam logic [31:0] INFO_LEN = 32'(NUM_DESC) * `SCL_DESC_SPAN;
    localparam logic [31:0] INFO_TOTAL = INFO_LEN + 32'(`SCL_INFO_HDR);

    scl_dst_t state_q, state_d;
    scl_op_t op_q, op_d;
    logic [15:0] len_q, len_d, alloc_q, alloc_d, cnt_q, cnt_d;
    logic [9:0] off_q, off_d;
    logic blkcmd_q, blkcmd_d, compl_q, compl_d;
    logic ise_q, ise_d, blk_q, blk_d, blkev_q, blkev_d, evbyte_q, evbyte_d;
    logic lock_q, lock_d, lor_q, lor_d, maker_q, maker_d;
    logic sess_q, sess_d, phys_q, phys_d;
    logic rej_q, rej_d, erase_d;
    logic rdy_q, done_q, rspv_q, rej_out_q, erase_q, enf_q, fwl_q, cert_q;
    logic [7:0] rspd_q, desc_byte, tx_byte;

    // Decode of the command being taken
    wire take = (state_q == D_IDLE) && link.req;
    wire is_blk = (link.proto == `SCL_PROTO_TCG) && (link.comid == `SCL_COMID_BLK) && (link.len != 16'h0000);
    wire is_compl = (link.proto == `SCL_PROTO_INFO) && (link.comid == `SCL_SPEC_COMPL);
    wire rx_last = (state_q == D_RX) && link.pay_valid && (cnt_q == 16'(len_q - 16'h0001));
    wire tx_last = (state_q == D_TX) && (cnt_q == 16'(alloc_q - 16'h0001));
    wire [31:0] pos32 = {16'h0000, cnt_q};
    wire [6:0] hw_idx = 7'(off_q - `SCL_OFF_HW);
    wire [6:0] ver_idx = 7'(off_q - `SCL_OFF_VER);
    wire [7:0] name_idx = 8'(off_q - `SCL_OFF_NAME);
    wire [1:0] len_sel = 2'(off_q - `SCL_OFF_LEN);
    wire [1:0] hdr_sel = cnt_q[1:0];
    wire [7:0] hw_byte = (off_q == `SCL_OFF_HW_END) ? 8'h00 : hw_str[8*hw_idx +: 8];
    wire [7:0] ver_byte = (off_q == `SCL_OFF_VER_END) ? 8'h00 : ver_str[8*ver_idx +: 8];
    wire [7:0] name_byte = (off_q == `SCL_DESC_LAST) ? 8'h00 : name_str[8*name_idx +: 8];

    // One byte of the cryptographic-module descriptor at offset off_q
    always_comb begin
        desc_byte = 8'h00; // Reserved bytes 2-3 and 10-15
        if (off_q == 10'h000) begin
            desc_byte = 8'(`SCL_DESC_TYPE >> 8);
        end else if (off_q == 10'h001) begin
            desc_byte = 8'(`SCL_DESC_TYPE & 16'h00FF);
        end else if ((off_q >= `SCL_OFF_LEN) && (off_q < `SCL_OFF_REL)) begin
            desc_byte = 8'(`SCL_DESC_LEN >> (8 * (3 - len_sel)));
        end else if (off_q == `SCL_OFF_REL) begin
            desc_byte = fips_rev3 ? `SCL_STD_REV3 : `SCL_STD_REV2;
        end else if (off_q == `SCL_OFF_LVL) begin
            desc_byte = sec_level;
        end else if ((off_q >= `SCL_OFF_HW) && (off_q < `SCL_OFF_VER)) begin
            desc_byte = hw_byte;
        end else if ((off_q >= `SCL_OFF_VER) && (off_q < `SCL_OFF_NAME)) begin
            desc_byte = ver_byte;
        end else if (off_q >= `SCL_OFF_NAME) begin
            desc_byte = name_byte;
        end
    end

    // Response byte at position cnt_q; anything past the data is pad
    always_comb begin
        tx_byte = `SCL_PAD;
        if (compl_q) begin
            if (pos32 < 32'(`SCL_INFO_HDR)) begin
                tx_byte = 8'(INFO_LEN >> (8 * (3 - hdr_sel)));
            end else if (pos32 < INFO_TOTAL) begin
                tx_byte = desc_byte;
            end
        end else if (op_q == OP_DISCOVERY) begin
            if (cnt_q == 16'h0000) begin
                tx_byte = 8'(`SCL_FEAT_BLK >> 8);
            end else if (cnt_q == 16'h0001) begin
                tx_byte = 8'(`SCL_FEAT_BLK & 16'h00FF);
            end
        end
    end

    // Sequencing and security state
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        len_d = len_q;
        alloc_d = alloc_q;
        cnt_d = cnt_q;
        off_d = off_q;
        blkcmd_d = blkcmd_q;
        compl_d = compl_q;
        ise_d = ise_q;
        blk_d = blk_q;
        blkev_d = blkev_q;
        evbyte_d = evbyte_q;
        lock_d = lock_q;
        lor_d = lor_q;
        maker_d = maker_q;
        sess_d = sess_q;
        phys_d = phys_q;
        rej_d = rej_q;
        erase_d = 1'b0;
        unique case (state_q)
            D_IDLE: begin
                if (take) begin
                    op_d = link.op;
                    len_d = link.len;
                    alloc_d = link.alloc;
                    blkcmd_d = is_blk;
                    compl_d = is_compl;
                    cnt_d = 16'h0000;
                    off_d = 10'h000;
                    rej_d = 1'b0;
                    state_d = D_DONE;
                    // Commands keep being answered in either mode
                    unique case (link.op)
                        OP_SEC_IN: begin
                            rej_d = !is_compl;
                            if (is_compl && (link.alloc != 16'h0000)) state_d = D_TX;
                        end
                        OP_DISCOVERY: begin
                            if (link.alloc != 16'h0000) state_d = D_TX;
                        end
                        OP_TSEND: begin
                            if (link.len != 16'h0000) state_d = D_RX; // No response bytes for it
                        end
                        OP_LOCK_ACCESS: ise_d = 1'b0;
                        OP_AUTH_OWNER: rej_d = blk_q;
                        OP_SESS_ADMIN: begin
                            sess_d = 1'b1;
                            phys_d = 1'b0;
                        end
                        OP_SESS_END: begin
                            sess_d = 1'b0;
                            phys_d = 1'b0;
                        end
                        OP_AUTH_PHYS: begin
                            rej_d = !sess_q;
                            phys_d = sess_q;
                        end
                        OP_REVERT: begin
                            rej_d = !(sess_q && phys_q);
                            if (sess_q && phys_q) begin
                                ise_d = 1'b1;
                                blk_d = 1'b0;
                                blkev_d = 1'b0;
                                lock_d = 1'b0;
                                lor_d = 1'b0;
                                maker_d = 1'b1;
                                erase_d = 1'b1;
                            end
                        end
                        OP_MAKER_OFF: maker_d = 1'b0;
                        OP_PORT_LOCK: begin
                            lock_d = link.arg[0];
                            lor_d = link.arg[1];
                        end
                        OP_HW_RESET: begin
                            sess_d = 1'b0;
                            phys_d = 1'b0;
                            if (blkev_q) blk_d = 1'b0;
                            if (lor_q) lock_d = 1'b1;
                        end
                        default: rej_d = 1'b1;
                    endcase
                end
            end
            D_RX: begin
                if (link.pay_valid) begin
                    cnt_d = 16'(cnt_q + 16'h0001);
                    if (cnt_q == 16'h0000) evbyte_d = link.pay_data[0];
                    if (rx_last) begin
                        state_d = D_DONE;
                        if (blkcmd_q) begin
                            blk_d = 1'b1;
                            blkev_d = (cnt_q == 16'h0000) ? link.pay_data[0] : evbyte_q;
                        end
                    end
                end
            end
            D_TX: begin
                cnt_d = 16'(cnt_q + 16'h0001);
                if (pos32 >= 32'(`SCL_INFO_HDR)) begin
                    off_d = (off_q == `SCL_DESC_LAST) ? 10'h000 : 10'(off_q + 10'h001);
                end
                if (tx_last) state_d = D_DONE;
            end
            D_DONE: state_d = D_IDLE;
            default: state_d = D_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= D_IDLE;
            op_q <= OP_SEC_IN;
            len_q <= 16'h0000;
            alloc_q <= 16'h0000;
            cnt_q <= 16'h0000;
            off_q <= 10'h000;
            blkcmd_q <= 1'b0;
            compl_q <= 1'b0;
            rej_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            len_q <= len_d;
            alloc_q <= alloc_d;
            cnt_q <= cnt_d;
            off_q <= off_d;
            blkcmd_q <= blkcmd_d;
            compl_q <= compl_d;
            rej_q <= rej_d;
        end
    end

    // Security state; reset is the power cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ise_q <= 1'b1;
            blk_q <= 1'b0;
            blkev_q <= 1'b0;
            evbyte_q <= 1'b0;
            lock_q <= 1'b0;
            lor_q <= 1'b0;
            maker_q <= 1'b1;
            sess_q <= 1'b0;
            phys_q <= 1'b0;
        end else begin
            ise_q <= ise_d;
            blk_q <= blk_d;
            blkev_q <= blkev_d;
            evbyte_q <= evbyte_d;
            lock_q <= lock_d;
            lor_q <= lor_d;
            maker_q <= maker_d;
            sess_q <= sess_d;
            phys_q <= phys_d;
        end
    end

    // Registered outputs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdy_q <= 1'b1;
            done_q <= 1'b0;
            rspv_q <= 1'b0;
            rspd_q <= 8'h00;
            rej_out_q <= 1'b0;
            erase_q <= 1'b0;
            enf_q <= 1'b0;
            fwl_q <= 1'b0;
            cert_q <= 1'b0;
        end else begin
            rdy_q <= (state_d == D_IDLE);
            done_q <= (state_d == D_DONE);
            rspv_q <= (state_q == D_TX);
            rspd_q <= (state_q == D_TX) ? tx_byte : 8'h00;
            rej_out_q <= rej_d && (state_d == D_DONE); // Reject flag stands only beside done
            erase_q <= erase_d;
            enf_q <= !ise_d;
            fwl_q <= lock_d && !ise_d;
            cert_q <= !maker_d && lock_d && lor_d;
        end
    end

    assign link.rdy = rdy_q;
    assign link.done = done_q;
    assign link.rej = rej_out_q;
    assign link.rsp_valid = rspv_q;
    assign link.rsp_data = rspd_q;
    assign ise_mode = ise_q;
    assign enforce_long_limits = enf_q;
    assign fw_port_locked = fwl_q;
    assign owner_auth_blocked = blk_q;
    assign user_data_erase = erase_q;
    assign certified = cert_q;
endmodule

// *** verilog/scl_host.sv ***
// Host-side controller: software registers in, link commands and command sequences out.
// Assumes the drive end on the link and a software master on the plain register port.
`timescale 1ns/1ps
`include "scl_regs.svh"
module scl_host import scl_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Software register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Link to drive
    scl_link_if.host link
);
    scl_hst_t state_q, state_d;
    scl_op_t op_q, op_d, step_op;
    scl_mac_t mac_q, mac_d;
    logic [2:0] step_q, step_d;
    logic step_end;
    logic [7:0] step_arg;
    logic [7:0] proto_q, arg_q;
    logic [15:0] comid_q, len_q, alloc_q, pcnt_q, pcnt_d, rcnt_q, rcnt_d;
    logic [31:0] rsp_q, rsp_d, rdata_q;
    logic ok_q, ok_d, req_q, pv_q;
    logic [7:0] pd_q;

    // Command sequences for zeroize and provisioning
    always_comb begin
        step_op = op_q;
        step_arg = arg_q;
        step_end = 1'b1;
        unique case (mac_q)
            MAC_ZEROIZE: begin
                step_end = (step_q == 3'h4);
                unique case (step_q)
                    3'h0: step_op = OP_SESS_ADMIN;
                    3'h1: step_op = OP_AUTH_PHYS;
                    3'h2: step_op = OP_REVERT;
                    3'h3: step_op = OP_SESS_END;
                    default: step_op = OP_HW_RESET;
                endcase
            end
            MAC_PROVISION: begin
                step_end = (step_q == 3'h3);
                unique case (step_q)
                    3'h0: step_op = OP_SESS_ADMIN;
                    3'h1: step_op = OP_MAKER_OFF;
                    3'h2: begin
                        step_op = OP_PORT_LOCK;
                        step_arg = `SCL_PROV_ARG;
                    end
                    default: step_op = OP_SESS_END;
                endcase
            end
            default: step_end = 1'b1;
        endcase
    end

    // Decodes
    wire go_wr = wr && (addr == `SCL_R_CTRL) && wdata[`SCL_CTRL_GO] && (state_q == H_IDLE);
    wire has_pay = (step_op == OP_TSEND) && (len_q != 16'h0000);
    wire issue = (state_q == H_ISSUE) && link.rdy;
    wire pay_last = (state_q == H_PAY) && (pcnt_q == 16'(len_q - 16'h0001));
    wire [7:0] pay_byte = (pcnt_q == 16'h0000) ? {7'h00, arg_q[0]} : 8'h00;
    wire [31:0] stat_word = {rcnt_q, 14'h0000, ok_q, (state_q != H_IDLE)};
    wire [31:0] rd_mux = (addr == `SCL_R_CTRL) ? {22'h000000, mac_q, op_q, 4'h0} :
                         (addr == `SCL_R_CMD) ? {8'h00, proto_q, comid_q} :
                         (addr == `SCL_R_LEN) ? {alloc_q, len_q} :
                         (addr == `SCL_R_ARG) ? {24'h000000, arg_q} :
                         (addr == `SCL_R_STAT) ? stat_word :
                         (addr == `SCL_R_RSP) ? rsp_q : 32'h0000_0000;

    // Sequencer
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        mac_d = mac_q;
        step_d = step_q;
        pcnt_d = pcnt_q;
        rcnt_d = rcnt_q;
        rsp_d = rsp_q;
        ok_d = ok_q;
        unique case (state_q)
            H_IDLE: begin
                if (go_wr) begin
                    op_d = scl_op_t'(wdata[`SCL_CTRL_OP]);
                    mac_d = scl_mac_t'(wdata[`SCL_CTRL_MAC]);
                    step_d = 3'h0;
                    state_d = H_ISSUE;
                end
            end
            H_ISSUE: begin
                if (issue) begin
                    pcnt_d = 16'h0000;
                    rcnt_d = 16'h0000;
                    rsp_d = 32'h0000_0000;
                    state_d = has_pay ? H_PAY : H_WAIT; // Payload for a send
                end
            end
            H_PAY: begin
                pcnt_d = 16'(pcnt_q + 16'h0001);
                if (pay_last) state_d = H_WAIT;
            end
            H_WAIT: begin
                if (link.rsp_valid) begin
                    rcnt_d = 16'(rcnt_q + 16'h0001);
                    if (rcnt_q < 16'h0004) rsp_d = {rsp_q[23:0], link.rsp_data};
                end
                if (link.done) begin
                    ok_d = !link.rej;
                    if (!link.rej && !step_end) begin
                        step_d = 3'(step_q + 3'h1);
                        state_d = H_ISSUE;
                    end else begin
                        state_d = H_IDLE;
                    end
                end
            end
            default: state_d = H_IDLE;
        endcase
    end

    // Software-written command fields
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            proto_q <= 8'h00;
            comid_q <= 16'h0000;
            len_q <= 16'h0000;
            alloc_q <= 16'h0000;
            arg_q <= 8'h00;
        end else if (wr && (state_q == H_IDLE)) begin
            if (addr == `SCL_R_CMD) {proto_q, comid_q} <= wdata[23:0];
            if (addr == `SCL_R_LEN) {alloc_q, len_q} <= wdata;
            if (addr == `SCL_R_ARG) arg_q <= wdata[7:0];
        end
    end

    // Sequencer state
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= H_IDLE;
            op_q <= OP_SEC_IN;
            mac_q <= MAC_SINGLE;
            step_q <= 3'h0;
            pcnt_q <= 16'h0000;
            rcnt_q <= 16'h0000;
            rsp_q <= 32'h0000_0000;
            ok_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            mac_q <= mac_d;
            step_q <= step_d;
            pcnt_q <= pcnt_d;
            rcnt_q <= rcnt_d;
            rsp_q <= rsp_d;
            ok_q <= ok_d;
        end
    end

    // Link drive and read data
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            req_q <= 1'b0;
            pv_q <= 1'b0;
            pd_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end else begin
            req_q <= issue;
            pv_q <= (state_q == H_PAY);
            pd_q <= (state_q == H_PAY) ? pay_byte : 8'h00;
            rdata_q <= rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign link.req = req_q;
    assign link.op = step_op;
    assign link.proto = proto_q;
    assign link.comid = comid_q;
    assign link.len = len_q;
    assign link.alloc = alloc_q;
    assign link.arg = step_arg;
    assign link.pay_valid = pv_q;
    assign link.pay_data = pd_q;
    assign rdata = rdata_q;
endmodule

// *** testbench/scl_checker.sv ***
// Link checker: handshake and response layout.
// Assumes one clock, sync active-high reset.
`timescale 1ns/1ps
module scl_checker import scl_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Link
    input wire logic req,
    input scl_op_t op,
    input wire logic [7:0] proto,
    input wire logic [15:0] comid,
    input wire logic [15:0] alloc,
    input wire logic pay_valid,
    input wire logic rdy,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic done,
    input wire logic rej
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire info = req && op == OP_SEC_IN && proto == 8'h00 && comid == 16'h0002 && alloc > 16'h000B;
    // Handshake
    a_req_rdy: assert property (req |-> rdy) else $error("req while busy");
    a_rdy_drop: assert property (req |=> !rdy) else $error("rdy held");
    a_rej_done: assert property (rej |-> done) else $error("lone rej");
    a_done_pulse: assert property (done |=> !done && rdy) else $error("done shape");
    a_lock_done: assert property (req && op == OP_LOCK_ACCESS |=> done && !rej) else $error("lock");
    // Response content
    a_send_quiet: assert property (pay_valid |-> !rsp_valid) else $error("send reply");
    a_disc_code: assert property (req && op == OP_DISCOVERY && alloc > 16'h0001 |->
        ##2 rsp_data == 8'h04 ##1 rsp_data == 8'h02) else $error("feature");
    a_info_len: assert property (info |-> ##2 rsp_valid && rsp_data == 8'h00
        ##2 rsp_data == 8'h02 ##1 rsp_data == 8'h10) else $error("info length");
    a_desc_type: assert property (info |-> ##7 rsp_data == 8'h01
        ##5 rsp_data == 8'h02 ##1 rsp_data == 8'h08) else $error("desc head");
    c_info: cover property (info);
    c_send: cover property (pay_valid);
    c_rej: cover property (rej);
endmodule

// *** testbench/tb_security_compliance_and_lock_state.sv ***
// Bench: host controller and drive logic on one link, driven from the register port.
// Assumes package, header and interface compiled first.
`timescale 1ns/1ps
`include "scl_regs.svh"
module tb_security_compliance_and_lock_state import scl_pkg::*;;
    logic clock = 0, sys_rst = 1, wr = 0, rd = 0, rev3 = 1;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata, st;
    logic instant_erase_mode, lim, plk, blk, ers, cert;
    logic [7:0] rx [0:599];
    int nrx, n_ers, error_cnt, total_checks;
    always #4 clock = ~clock;
    scl_link_if lk ();
    scl_dev scl_dev_inst (.clock(clock), .sys_rst(sys_rst), .link(lk), .fips_rev3(rev3), .sec_level(8'h31),
        .hw_str(1024'h41), .ver_str(1024'h42), .name_str(2048'h43), .ise_mode(instant_erase_mode), .enforce_long_limits(lim),
        .fw_port_locked(plk), .owner_auth_blocked(blk), .user_data_erase(ers), .certified(cert));
    scl_host scl_host_inst (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .link(lk));
    scl_checker scl_checker_inst (.clock(clock), .sys_rst(sys_rst), .req(lk.req), .op(lk.op), .proto(lk.proto),
        .comid(lk.comid), .alloc(lk.alloc), .pay_valid(lk.pay_valid), .rdy(lk.rdy), .rsp_valid(lk.rsp_valid),
        .rsp_data(lk.rsp_data), .done(lk.done), .rej(lk.rej));
    // Collect response bytes and erase pulses
    always @(negedge clock) begin
        if (lk.rsp_valid) rx[nrx++] = lk.rsp_data;
        if (ers) n_ers++;
    end
    task chk(input logic [31:0] e, input logic [31:0] g, input string w);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clock);
        wr <= 0;
    endtask
    task rreg(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1;
        @(posedge clock);
        rd <= 0;
        #1 st = rdata;
    endtask
    // One command or sequence, then poll busy with a bound
    task run(input scl_op_t o, input logic [1:0] m, input logic [31:0] c, input logic [31:0] l, input logic [7:0] g);
        int i;
        nrx = 0;
        wreg(`SCL_R_CMD, c);
        wreg(`SCL_R_LEN, l);
        wreg(`SCL_R_ARG, {24'h0, g});
        wreg(`SCL_R_CTRL, {22'h0, m, o, 4'h1});
        repeat (2) @(posedge clock);
        st = 32'h0000_0001;
        for (i = 0; i < 3000 && st[0] !== 1'b0; i++)
            rreg(`SCL_R_STAT);
        if (i == 3000) begin
            error_cnt++;
            stop_test;
        end
    endtask
    task t_info(input logic r);
        int k;
        static int p [22] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 13, 14, 19, 20, 147, 148, 275, 276, 531, 539};
        static logic [175:0] v = 176'h0000021000010000000002083100004100420043_0000;
        @(posedge clock);
        rev3 <= r;
        run(OP_SEC_IN, 2'h0, 32'h0000_0002, 32'h021C_0000, 8'h00);
        chk(540, nrx, "count");
        chk({7'h19, r}, rx[12], "standard");
        for (k = 0; k < 22; k++)
            chk(v[175 - 8 * k -: 8], rx[p[k]], "byte");
    endtask
    task t_block(input logic f);
        run(OP_TSEND, 2'h0, 32'h0002_0005, 32'h0000_0001, {7'h0, f});
        chk(1, blk, "blocked");
        run(OP_AUTH_OWNER, 2'h0, 0, 0, 0);
        chk(0, st[1], "owner ok");
        run(OP_HW_RESET, 2'h0, 0, 0, 0);
        chk(!f, blk, "after reset");
    endtask
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 0;
        chk(1, instant_erase_mode, "ise");
        chk(0, lim, "limits");
        t_info(1);
        t_info(0);
        run(OP_DISCOVERY, 2'h0, 0, 32'h0004_0000, 0);
        chk(32'h0402_0000, {rx[0], rx[1], rx[2], rx[3]}, "feature");
        rreg(`SCL_R_RSP);
        chk(32'h0402_0000, st, "rsp word");
        run(OP_LOCK_ACCESS, 2'h0, 0, 0, 0);
        chk(1, {instant_erase_mode, lim}, "mode");
        t_block(0);
        run(OP_SEC_IN, 2'h1, 0, 0, 0);
        chk(32'hA_0001, {instant_erase_mode, blk, st[1:0], n_ers[15:0]}, "zeroize");
        t_block(1);
        run(OP_LOCK_ACCESS, 2'h0, 0, 0, 0);
        run(OP_SEC_IN, 2'h2, 0, 0, 0);
        chk(3, {cert, plk}, "provision");
        stop_test;
    end
endmodule
